// [logic/clock_switch_mux.sv]
// Two-input glitchless clock switch with fail-safe input guard and fanout.
// Assumes both reference clocks, swing flags and select are sampled by clk,
// and that the reference clocks run well below half the clk rate.
//
// Operation
// - No shortened phase while switching
// - Both inputs switch the same way
// - Bypass mode switches at once
// - Weak input freezes output at last level
// - Follow old, hold low, follow new
// - Stuck high: hold high, low, follow
// - Stretched phases exceed half new period
// - Stuck low: hold low, then follow
// - Dead input uses last valid level
// - Zero swing gives stable output
// - Slow degradation not filtered
// - Synchronised select, counts vary slightly
// - Power-on hold before switching starts, skipped in bypass mode
// - Low select first, high second input
// - Open select means second input
// - Switch done within seventeen cycles
`timescale 1ns/1ps

module clock_switch_mux
   import clock_switch_pkg::*;
#(
   parameter int POR_LEN   = clock_switch_pkg::POR_CYCLES,   // Startup hold
   parameter int STUCK_LEN = clock_switch_pkg::STUCK_CYCLES  // Dead-clock limit
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // Reference clocks and their swing flags
   input  wire logic              clock_input_a,
   input  wire logic              clock_input_b,
   input  wire logic              swing_ok_a,
   input  wire logic              swing_ok_b,
   // Selection and mode
   input  wire logic              input_select,
   input  wire logic              select_open,
   input  wire logic              startup_delay_pin_at_supply,
   // Switched clock copies
   output logic [clock_switch_pkg::N_OUT-1:0] clock_out
);
   import clock_switch_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   sw_state_t   r_reg;          // Registered state
   sw_state_t   r_next;         // Next state
   logic [1:0]  raw;            // Sampled inputs
   logic [1:0]  ok;             // Swing flags
   logic [1:0]  eff;            // Guarded levels
   logic [1:0]  rise;           // Rising edges of guarded levels
   logic [1:0]  fall;           // Falling edges of guarded levels
   logic        sel_in;         // Select after pull-up
   logic        bypass;         // Suppressor disabled
   logic        alt;            // Input being switched to

   assign raw    = {clock_input_b, clock_input_a};
   assign ok     = {swing_ok_b, swing_ok_a};
   assign sel_in = select_open ? 1'b1 : input_select;
   assign bypass = startup_delay_pin_at_supply;
   assign alt    = ~r_reg.cur;

   // ************************************************************
   // Fail-safe guard
   // ************************************************************
   // hold last valid level
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         eff[i] = ok[i] ? raw[i] : r_reg.last[i];
      end
      rise = eff & ~r_reg.prev;
      fall = ~eff & r_reg.prev;
   end

   // ************************************************************
   // Switchover state machine
   // ************************************************************
   // Indexing by cur keeps both inputs symmetric
   always_comb begin
      r_next          = r_reg;
      r_next.sel_meta = sel_in;
      r_next.sel_sync = r_reg.sel_meta;
      r_next.prev     = eff;
      for (int i = 0; i < 2; i++) begin
         if (ok[i]) begin
            r_next.last[i] = raw[i];
         end
      end
      // Dead-clock timer on the driving input
      if (rise[r_reg.cur] || fall[r_reg.cur]) begin
         r_next.idle = '0;
      end else if (r_reg.idle != IDLE_W'(STUCK_LEN)) begin
         r_next.idle = r_reg.idle + 1'b1;
      end
      unique case (r_reg.fsm)
         ST_POR: begin
            // hold low until startup ends
            // The first pulse after startup may be short: the suppressor
            // guards select changes, not the exit from the startup hold
            r_next.out = 1'b0;
            r_next.cur = r_reg.sel_sync;
            if (bypass || r_reg.por == POR_W'(POR_LEN - 1)) begin
               r_next.fsm = ST_FOLLOW;
            end else begin
               r_next.por = r_reg.por + 1'b1;
            end
         end
         ST_FOLLOW: begin
            r_next.out = eff[r_reg.cur];
            r_next.cnt = '0;
            if (r_reg.sel_sync != r_reg.cur) begin
               if (bypass) begin
                  r_next.cur = r_reg.sel_sync;
                  r_next.out = eff[r_reg.sel_sync];
               end else begin
                  r_next.fsm  = ST_DRAIN;
                  r_next.idle = '0;
               end
            end
         end
         ST_DRAIN: begin
            // keep old clock a few pulses
            r_next.out = eff[r_reg.cur];
            if (fall[r_reg.cur]) begin
               r_next.cnt = r_reg.cnt + 1'b1;
               if (r_reg.cnt == CNT_W'(DRAIN_PULSES - 1)) begin
                  r_next.fsm = ST_LOW_WAIT;
                  r_next.cnt = '0;
               end
            end else if (r_reg.idle == IDLE_W'(STUCK_LEN)) begin
               r_next.cnt = '0;
               if (eff[r_reg.cur]) begin
                  r_next.fsm = ST_HOLD_HIGH;
                  r_next.out = 1'b1;
               end else begin
                  r_next.fsm = ST_LOW_WAIT;
                  r_next.out = 1'b0;
               end
            end
         end
         ST_HOLD_HIGH: begin
            r_next.out = 1'b1;
            if (fall[alt]) begin
               r_next.cnt = r_reg.cnt + 1'b1;
               if (r_reg.cnt == CNT_W'(HIGH_PULSES - 1)) begin
                  r_next.fsm = ST_LOW_WAIT;
                  r_next.cnt = '0;
                  r_next.out = 1'b0;
               end
            end
         end
         ST_LOW_WAIT: begin
            // low until the new clock has fallen LOW_EDGES times
            r_next.out = 1'b0;
            if (fall[alt]) begin
               r_next.cnt = r_reg.cnt + 1'b1;
               if (r_reg.cnt == CNT_W'(LOW_EDGES - 1)) begin
                  // hand over to the other input
                  r_next.fsm = ST_FOLLOW;
                  r_next.cur = alt;
                  r_next.cnt = '0;
               end
            end
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         r_reg.fsm      <= ST_POR;
         r_reg.cur      <= RST_SELECT;
         r_reg.sel_meta <= RST_SELECT;
         r_reg.sel_sync <= RST_SELECT;
         r_reg.prev     <= '0;
         r_reg.last     <= '0;
         r_reg.cnt      <= '0;
         r_reg.idle     <= '0;
         r_reg.por      <= '0;
         r_reg.out      <= 1'b0;
      end else begin
         r_reg <= r_next;
      end
   end

   // ************************************************************
   // Fanout
   // ************************************************************
   // same clock on every copy
   always_ff @(posedge clk) begin
      if (srst) begin
         clock_out <= '0;
      end else begin
         clock_out <= {N_OUT{r_next.out}};
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   // is the sources' duty; the stage counts assume it
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_bypass_switch: assert property (
      bypass && r_reg.fsm == ST_FOLLOW && r_reg.sel_sync != r_reg.cur
      |=> r_reg.cur == $past(r_reg.sel_sync))
      else $error("bypass switch not immediate");

   a_por_quiet: assert property (
      r_reg.fsm == ST_POR |=> clock_out == '0)
      else $error("output toggled during startup");

   a_copies_equal: assert property (
      (&clock_out) || (~|clock_out))
      else $error("output copies differ");

   a_low_stage: assert property (
      r_reg.fsm == ST_LOW_WAIT && !fall[alt] |=> !r_reg.out && r_reg.fsm == ST_LOW_WAIT)
      else $error("low stage left early");

   a_high_stage: assert property (
      r_reg.fsm == ST_HOLD_HIGH && !fall[alt] |=> r_reg.out && r_reg.fsm == ST_HOLD_HIGH)
      else $error("stretched high broken");

   a_freeze_weak: assert property (
      r_reg.fsm == ST_FOLLOW && !ok[r_reg.cur] && r_reg.sel_sync == r_reg.cur
      ##1 r_reg.fsm == ST_FOLLOW && !ok[r_reg.cur] |=> $stable(r_reg.out))
      else $error("output followed weak input");

   // Not from the edge of reset release, the sync flops start at the reset select
   a_select_sync: assert property (
      (!srst && $stable(sel_in)) ##1 $stable(sel_in)[*2] |-> r_reg.sel_sync == sel_in)
      else $error("select sync latency wrong");

   a_open_select: assert property (
      select_open[*3] |-> r_reg.sel_sync)
      else $error("open select not high");

   a_stuck_exit: assert property (
      r_reg.fsm == ST_DRAIN && r_reg.idle == IDLE_W'(STUCK_LEN) && !fall[r_reg.cur]
      |=> r_reg.fsm == ($past(eff[r_reg.cur]) ? ST_HOLD_HIGH : ST_LOW_WAIT)
          && r_reg.out == $past(eff[r_reg.cur]))
      else $error("dead clock path wrong");

   a_handover: assert property (
      r_reg.fsm == ST_LOW_WAIT ##1 r_reg.fsm == ST_FOLLOW
      |-> r_reg.cur != $past(r_reg.cur) && !r_reg.out)
      else $error("handover not clean");

   a_follow_input: assert property (
      r_reg.fsm == ST_FOLLOW && r_reg.sel_sync == r_reg.cur && ok[r_reg.cur]
      |=> r_reg.out == $past(raw[r_reg.cur]))
      else $error("output not following chosen input");

   a_drain_follow: assert property (
      r_reg.fsm == ST_DRAIN && r_reg.idle != IDLE_W'(STUCK_LEN)
      |=> r_reg.out == $past(eff[r_reg.cur]))
      else $error("drain stage dropped old clock");

   a_bypass_plain: assert property (
      bypass |-> r_reg.fsm == ST_POR || r_reg.fsm == ST_FOLLOW)
      else $error("staged switch while bypassed");

   // handover only while new clock is low
   a_new_low: assert property (
      r_reg.fsm == ST_LOW_WAIT ##1 r_reg.fsm == ST_FOLLOW |-> !$past(eff[alt]))
      else $error("handover with new clock high");

   c_normal_switch: cover property (
      r_reg.fsm == ST_DRAIN ##1 r_reg.fsm == ST_LOW_WAIT);
   c_stuck_high: cover property (r_reg.fsm == ST_HOLD_HIGH);
   c_bypass_move: cover property (bypass && $changed(r_reg.cur));
   c_weak_input: cover property (r_reg.fsm == ST_FOLLOW && !ok[r_reg.cur]);
   c_stuck_low: cover property (
      r_reg.fsm == ST_DRAIN && r_reg.idle == IDLE_W'(STUCK_LEN) && !eff[r_reg.cur]);

endmodule // clock_switch_mux

// [include/clock_switch_pkg.sv]
// Shared constants and state types for the glitchless clock switch.
// Assumes one 250 MHz system clock that samples both reference clocks.
package clock_switch_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS  = 4;       // System clock period
   localparam int POR_TIME_NS    = 1000;    // Startup hold time
   localparam int POR_CYCLES     = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STUCK_TIME_NS  = 256;     // No-edge time that marks a dead clock
   localparam int STUCK_CYCLES   = (STUCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ************************************************************
   // Switchover stage lengths, in input clock pulses, and output copy count
   // ************************************************************
   localparam int DRAIN_PULSES   = 2;       // Old clock pulses kept after select
   localparam int HIGH_PULSES    = 2;       // Stretched high, in new clock pulses
   localparam int LOW_EDGES      = 2;       // Forced low, in new clock falls
   localparam int N_OUT          = 8;       // Output copies

   // ************************************************************
   // Field widths and reset values
   // ************************************************************
   localparam int CNT_W          = 4;
   localparam int IDLE_W         = 8;
   localparam int POR_W          = 12;
   localparam logic RST_SELECT   = 1'b1;    // Second input after reset

   // One-hot switchover states
   typedef enum logic [4:0] {
      ST_POR       = 5'h01,
      ST_FOLLOW    = 5'h02,
      ST_DRAIN     = 5'h04,
      ST_HOLD_HIGH = 5'h08,
      ST_LOW_WAIT  = 5'h10
   } state_t;

   // Whole state of the switch
   typedef struct packed {
      state_t              fsm;      // Switchover stage
      logic                cur;      // Input now driving the output
      logic                sel_meta; // Select, first sync stage
      logic                sel_sync; // Select, second sync stage
      logic [1:0]          prev;     // Guarded input levels, last cycle
      logic [1:0]          last;     // Last valid level per input
      logic [CNT_W-1:0]    cnt;      // Pulse or edge count of a stage
      logic [IDLE_W-1:0]   idle;     // Cycles since old clock toggled
      logic [POR_W-1:0]    por;      // Startup counter
      logic                out;      // Switched clock
   } sw_state_t;

endpackage

// [dv/ref_clock_pair.sv]
// Two free-running reference clocks for the glitchless clock switch.
// Assumes it is stepped by the same clk that samples it in the switch.
`timescale 1ns/1ps
module ref_clock_pair #(
   parameter int HALF_A = 5,   // Half period of a, clk cycles
   parameter int HALF_B = 6    // Half period of b, clk cycles
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Freeze controls, a held clock keeps its level
   input  wire logic hold_a,
   input  wire logic hold_b,
   // Reference clocks
   output logic      clock_input_a,
   output logic      clock_input_b
);
   // ************************************************************
   // Phase counters
   // ************************************************************
   int cnt_a;   // Cycles spent in current phase of a
   int cnt_b;   // Cycles spent in current phase of b

   // Reset only realigns the sources; a frozen source models a dead clock
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_a         <= 0;
         cnt_b         <= 0;
         clock_input_a <= 1'b0;
         clock_input_b <= 1'b0;
      end else begin
         if (!hold_a) begin
            cnt_a         <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
            clock_input_a <= (cnt_a == HALF_A - 1) ? ~clock_input_a : clock_input_a;
         end
         if (!hold_b) begin
            cnt_b         <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
            clock_input_b <= (cnt_b == HALF_B - 1) ? ~clock_input_b : clock_input_b;
         end
      end
   end
endmodule // ref_clock_pair

// [dv/tb_top.sv]
// Self-checking bench for the glitchless clock switch.
// Assumes shortened startup and dead-clock counts, and a 250 MHz clk.
`timescale 1ns/1ps
module tb_top;
   import clock_switch_pkg::*;
   localparam int HALF_A  = 5;                    // Phase of a
   localparam int HALF_B  = 6;                    // Phase of b
   localparam int LIMIT   = 17 * 2 * HALF_B + 40; // Select to follow
   localparam int CEILING = 5000;                 // Hang guard
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic a_clk, b_clk;
   logic ok_a = 1'b1;
   logic ok_b = 1'b1;
   logic sel = 1'b0;
   logic sel_open = 1'b1;
   logic bypass = 1'b0;
   logic hold_a = 1'b0;
   logic hold_b = 1'b0;
   logic [N_OUT-1:0] clock_out;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;

   ref_clock_pair #(.HALF_A(HALF_A), .HALF_B(HALF_B)) u_ref_clock_pair (.clk(clk), .srst(srst),
      .hold_a(hold_a), .hold_b(hold_b), .clock_input_a(a_clk), .clock_input_b(b_clk));
   clock_switch_mux #(.POR_LEN(8), .STUCK_LEN(16)) u_clock_switch_mux (.clk(clk), .srst(srst),
      .clock_input_a(a_clk), .clock_input_b(b_clk), .swing_ok_a(ok_a), .swing_ok_b(ok_b),
      .input_select(sel), .select_open(sel_open), .startup_delay_pin_at_supply(bypass),
      .clock_out(clock_out));

   // ************************************************************
   // Reporting and hang guard
   // ************************************************************
   initial forever #2 clk = ~clk;

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic err(input string what, input logic [15:0] exp, input logic [15:0] got);
      bad_count++;
      compares++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == CEILING) begin
         err("timeout", CEILING, cycles);
         close_out();
      end
   end

   // All copies must match at every sample
   always @(negedge clk) begin
      if (srst === 1'b0 && clock_out !== {N_OUT{clock_out[0]}}) err("copies", 1, 0);
      else compares++;
   end

   // ************************************************************
   // Phase measurement
   // ************************************************************
   task automatic sync_edge();
      logic v;
      int n;
      v = clock_out[0];
      n = 0;
      while (clock_out[0] === v && n < 300) begin
         @(negedge clk);
         n++;
      end
   endtask

   // Length of the phase that starts at this sample
   task automatic get_run(output int len, output logic lvl);
      lvl = clock_out[0];
      len = 0;
      while (clock_out[0] === lvl && len < 300) begin
         @(negedge clk);
         len++;
      end
   endtask

   task automatic check_follow(input int half);
      int len;
      logic lvl;
      // Skip the phase in progress, it may be cut short
      @(negedge clk);
      repeat (2) sync_edge();
      repeat (2) begin
         get_run(len, lvl);
         if (len !== half) err("phase length", half, len);
         else compares++;
      end
   endtask

   // Switch, then demand clean phases and a bounded arrival on the new clock
   task automatic switch_over(input logic to, input int half, input int lo, input int hi);
      int len, t, hit, mlo, mhi;
      logic lvl, first;
      t = 0; hit = 0; mlo = 0; mhi = 0; first = 1'b1;
      @(posedge clk);
      sel <= to;
      sel_open <= 1'b0;
      @(negedge clk);
      while (hit < 2 && t < LIMIT) begin
         get_run(len, lvl);
         t += len;
         hit = (len == half) ? hit + 1 : 0;
         if (!first && len < HALF_A) err("runt phase", HALF_A, len);
         else compares++;
         if (lvl && len > mhi) mhi = len;
         if (!lvl && len > mlo) mlo = len;
         first = 1'b0;
      end
      if (hit !== 2) err("follow new", 2, hit);
      else compares++;
      if (mlo < lo) err("held low", lo, mlo);
      else compares++;
      if (mhi < hi) err("held high", hi, mhi);
      else compares++;
      if (hi == 0 && mhi > HALF_B) err("high without stretch", HALF_B, mhi);
      else compares++;
   endtask

   task automatic freeze(input logic b_side, input logic lvl);
      int n;
      n = 0;
      while ((b_side ? b_clk : a_clk) === lvl && n < 100) begin
         @(negedge clk);
         n++;
      end
      while ((b_side ? b_clk : a_clk) !== lvl && n < 100) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      if (b_side) hold_b <= 1'b1;
      else hold_a <= 1'b1;
   endtask

   task automatic weak_input();
      logic lvl;
      @(posedge clk);
      ok_b <= 1'b0;
      repeat (4) @(negedge clk);
      lvl = clock_out[0];
      repeat (40) begin
         @(negedge clk);
         if (clock_out[0] !== lvl) err("frozen level", lvl, clock_out[0]);
         else compares++;
      end
      // Frozen high must take the stretched path, frozen low the plain one
      switch_over(1'b0, HALF_A, HALF_B + 1, lvl ? HALF_B + 1 : 0);
      @(posedge clk);
      ok_b <= 1'b1;
   endtask

   task automatic plain_mux();
      @(posedge clk);
      srst <= 1'b1;
      bypass <= 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      check_follow(HALF_A);
      @(posedge clk);
      sel <= 1'b1;
      repeat (6) @(posedge clk);
      check_follow(HALF_B);
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      if (clock_out !== 8'h00) err("reset out", 0, clock_out);
      else compares++;
      @(posedge clk);
      srst <= 1'b0;
      repeat (6) begin
         @(negedge clk);
         if (clock_out !== 8'h00) err("startup hold", 0, clock_out);
         else compares++;
      end
      check_follow(HALF_B);
      switch_over(1'b0, HALF_A, HALF_B + 1, 0);
      switch_over(1'b1, HALF_B, HALF_B + 1, 0);
      freeze(1'b1, 1'b0);
      switch_over(1'b0, HALF_A, HALF_B + 1, 0);
      @(posedge clk);
      hold_b <= 1'b0;
      freeze(1'b0, 1'b1);
      switch_over(1'b1, HALF_B, HALF_B + 1, HALF_B + 1);
      @(posedge clk);
      hold_a <= 1'b0;
      check_follow(HALF_B);
      weak_input();
      plain_mux();
      close_out();
   end
endmodule // tb_top
